// [osd_engine.sv]
`timescale 1ns/1ns
module osd_engine
  import osd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Sync inputs, active low
  input wire logic hsync_n,
  input wire logic vsync_n,
  // Control flags
  input wire logic osd_display_on_flag,
  input wire logic glyph_rom_bank_select,
  // Peripheral register port
  input wire logic [7:0] periph_addr,
  input wire logic periph_wr,
  input wire logic [7:0] periph_wdata,
  output logic [7:0] periph_rdata,
  // Video memory item stream
  output logic [6:0] vram_idx,
  input wire osd_item_type vram_item,
  // Glyph ROM
  output logic [10:0] rom_addr,
  input wire logic [15:0] rom_data,
  // Video pixel stream with ready input
  output logic pix_valid,
  input wire logic pix_ready,
  output osd_pix_type pix_out
);
  logic [7:0] start_pos_ff;
  osd_state_type state_ff;
  osd_ctrl_type ctrl_ff;
  logic [1:0] row_vsize_ff;
  logic hs_d_ff;
  logic vs_d_ff;
  logic [7:0] line_ff;
  logic [6:0] row_base_ff;
  logic [6:0] idx_ff;
  logic [6:0] row_top_ff;
  logic [7:0] row_line_ff;
  logic [5:0] char_sel_ff;
  logic [15:0] pat_ff;
  logic [15:0] hcnt_ff;
  logic [15:0] hgoal_ff;
  logic [3:0] dot_ff;
  logic [1:0] rep_ff;
  logic [7:0] dcyc_ff;
  logic [4:0] col_ff;
  logic first_row_ff;
  logic first_in_row_ff;
  logic pend_blank_ff;
  logic cr_seen_ff;
  logic [3:0] gline_ff;
  logic [1:0] gsub_ff;
  logic line_go_ff;
  logic screen_done_ff;
  logic [7:0] vstart_lines;
  logic hs_rise;
  logic vs_rise;
  logic buf_in_ready;
  logic dot_on;
  logic [15:0] rimmask;
  osd_pix_type pix_nxt;
  osd_ctrl_type cw;

  // Size multiplier 1..4 from a two-bit field
  function automatic logic [2:0] mult(input logic [1:0] s);
    return {1'b0, s} + 3'h1;
  endfunction

  assign hs_rise = hsync_n && !hs_d_ff;
  assign vs_rise = vsync_n && !vs_d_ff;
  assign vstart_lines = 8'(VSTART_BASE_LINES) + {4'h0, start_pos_ff[3:0]};
  // Control word at step F, top bit ignored
  assign cw = osd_decode({1'b0, rom_data[14:0]});

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      start_pos_ff <= START_POS_RESET;
    end else if (periph_wr && periph_addr == START_POS_ADDR) begin
      start_pos_ff <= periph_wdata;
    end
  end
  assign periph_rdata = (periph_addr == START_POS_ADDR) ? start_pos_ff : 8'h00;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hs_d_ff <= 1'b1;
      vs_d_ff <= 1'b1;
    end else begin
      hs_d_ff <= hsync_n;
      vs_d_ff <= vsync_n;
    end
  end

  // First hsync after vsync rise is line one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      line_ff <= 8'h00;
    end else if (!vsync_n) begin
      line_ff <= 8'h00;
    end else if (hs_rise && line_ff != 8'hFF) begin
      line_ff <= line_ff + 8'h01;
    end
  end

  // Bank and select address the control step
  always_comb begin
    rom_addr = {glyph_rom_bank_select, char_sel_ff, gline_ff};
    if (state_ff == ST_FETCH) begin
      rom_addr = {glyph_rom_bank_select, vram_item.code[5:0], CTRL_STEP};
    end
  end
  assign vram_idx = idx_ff;

  // Rim bit widens the blanked area
  assign rimmask = pat_ff[PAT_RIM_BIT] ?
    ({6'h00, pat_ff[9:0]} | {7'h00, pat_ff[9:1]} | {6'h00, pat_ff[8:0], 1'b0}) : {6'h00, pat_ff[9:0]};
  assign dot_on = pat_ff[4'(CHAR_DOTS - 1) - dot_ff];

  always_comb begin
    pix_nxt.r = dot_on && ctrl_ff.color[2];
    pix_nxt.g = dot_on && ctrl_ff.color[1];
    pix_nxt.b = dot_on && ctrl_ff.color[0];
    pix_nxt.blank = pix_nxt.r || pix_nxt.g || pix_nxt.b;
    if (pat_ff[PAT_RIM_BIT]) begin
      pix_nxt.blank = rimmask[4'(CHAR_DOTS - 1) - dot_ff];
    end
    if (state_ff != ST_DRAW || pend_blank_ff) begin
      pix_nxt = '0;
    end
  end

  // Main sequencing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      ctrl_ff <= '0;
      row_vsize_ff <= 2'h0;
      idx_ff <= 7'h00;
      row_base_ff <= 7'h00;
      row_top_ff <= 7'h00;
      row_line_ff <= 8'h00;
      char_sel_ff <= 6'h00;
      pat_ff <= 16'h0000;
      hcnt_ff <= 16'h0000;
      hgoal_ff <= 16'h0000;
      dot_ff <= 4'h0;
      rep_ff <= 2'h0;
      dcyc_ff <= 8'h00;
      col_ff <= 5'h00;
      first_row_ff <= 1'b1;
      first_in_row_ff <= 1'b1;
      pend_blank_ff <= 1'b0;
      cr_seen_ff <= 1'b0;
      gline_ff <= 4'h0;
      gsub_ff <= 2'h0;
      line_go_ff <= 1'b0;
      screen_done_ff <= 1'b0;
    end else if (!osd_display_on_flag || vs_rise) begin
      screen_done_ff <= 1'b0;
      state_ff <= osd_display_on_flag ? ST_VWAIT : ST_IDLE;
      idx_ff <= 7'h00;
      row_base_ff <= 7'h00;
      first_row_ff <= 1'b1;
      first_in_row_ff <= 1'b1;
      cr_seen_ff <= 1'b0;
    end else begin
      if (hs_rise) begin
        hcnt_ff <= 16'h0000;
      end else begin
        hcnt_ff <= hcnt_ff + 16'h0001;
      end
      unique case (state_ff)
        ST_IDLE: begin
          if (!screen_done_ff) begin
            state_ff <= ST_VWAIT;
          end
        end
        ST_VWAIT: begin
          if (line_ff >= vstart_lines) begin
            state_ff <= ST_FETCH;
            row_line_ff <= 8'h00;
            row_top_ff <= 7'h00;
            line_go_ff <= 1'b1;
            gline_ff <= 4'h0;
            gsub_ff <= 2'h0;
          end
        end
        ST_FETCH: begin
          idx_ff <= idx_ff + 7'h01;
          if (vram_item.tag == TAG_CTRL) begin
            ctrl_ff <= cw;
            // Select comes only from video memory
            pend_blank_ff <= 1'b1;
            if (first_in_row_ff) begin
              row_vsize_ff <= cw.vsize;
              row_top_ff <= 7'(cw.vpos * mult(cw.vsize) * CHAR_LINES);
              col_ff <= {1'b0, cw.hpos};
            end else begin
              col_ff <= col_ff + {1'b0, cw.hpos};
            end
            first_in_row_ff <= 1'b0;
          end else if (vram_item.tag == TAG_CR) begin
            cr_seen_ff <= 1'b1;
            state_ff <= ST_LINEEND;
            if (cr_seen_ff && first_in_row_ff) begin
              state_ff <= ST_IDLE;
              screen_done_ff <= 1'b1;
            end
          end else begin
            cr_seen_ff <= 1'b0;
            char_sel_ff <= vram_item.code[5:0];
            state_ff <= ST_ROWWAIT;
          end
        end
        ST_ROWWAIT: begin
          if (line_go_ff && row_line_ff >= {1'b0, row_top_ff}) begin
            line_go_ff <= 1'b0;
            // Start delay plus one dot per step
            hgoal_ff <= 16'(HBASE_CYC) + 16'(DOT_CYC) * {12'h000, start_pos_ff[7:4]}
              + 16'(DOT_CYC * CHAR_DOTS) * {8'h00, col_ff[4:0]} * {13'h0000, mult(ctrl_ff.hsize)};
            state_ff <= ST_HWAIT;
          end else if (hs_rise) begin
            row_line_ff <= row_line_ff + 8'h01;
            line_go_ff <= 1'b1;
          end
        end
        ST_HWAIT: begin
          pat_ff <= rom_data;
          if (hcnt_ff >= hgoal_ff) begin
            state_ff <= ST_DRAW;
            dot_ff <= 4'h0;
            rep_ff <= 2'h0;
            dcyc_ff <= 8'h00;
            pend_blank_ff <= 1'b0;
          end
        end
        ST_DRAW: begin
          if (buf_in_ready) begin
            dcyc_ff <= dcyc_ff + 8'h01;
            if (dcyc_ff == 8'(DOT_CYC - 1)) begin
              dcyc_ff <= 8'h00;
              rep_ff <= rep_ff + 2'h1;
              if (rep_ff == ctrl_ff.hsize) begin
                rep_ff <= 2'h0;
                dot_ff <= dot_ff + 4'h1;
                if (dot_ff == 4'(CHAR_DOTS - 1)) begin
                  col_ff <= (col_ff < 5'(ROW_POSITIONS - 1)) ? col_ff + 5'h01 : col_ff;
                  state_ff <= ST_FETCH;
                end
              end
            end
          end
        end
        ST_LINEEND: begin
          if (hs_rise) begin
            row_line_ff <= row_line_ff + 8'h01;
            line_go_ff <= 1'b1;
            if (row_line_ff + 8'h01 >= {1'b0, row_top_ff} + 8'(mult(row_vsize_ff) * CHAR_LINES)) begin
              row_base_ff <= idx_ff;
              first_in_row_ff <= 1'b1;
              row_line_ff <= 8'h00;
              first_row_ff <= 1'b0;
              gline_ff <= 4'h0;
              gsub_ff <= 2'h0;
            end else begin
              idx_ff <= row_base_ff;
              first_in_row_ff <= 1'b1;
              if (gsub_ff == row_vsize_ff) begin
                gsub_ff <= 2'h0;
                gline_ff <= gline_ff + 4'h1;
              end else begin
                gsub_ff <= gsub_ff + 2'h1;
              end
            end
            state_ff <= ST_FETCH;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  osd_pix_buf u_buf (
    .clk(clk),
    .rst(rst),
    .in_valid(state_ff == ST_DRAW),
    .in_ready(buf_in_ready),
    .in_data(pix_nxt),
    .out_valid(pix_valid),
    .out_ready(pix_ready),
    .out_data(pix_out)
  );
endmodule

// [osd_engine_chk.sv]
`timescale 1ns/1ns
module osd_engine_chk
  import osd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Engine inputs
  input wire logic hsync_n,
  input wire logic vsync_n,
  input wire logic glyph_rom_bank_select,
  input wire logic [7:0] periph_addr,
  input wire logic periph_wr,
  input wire logic [7:0] periph_wdata,
  input wire logic pix_ready,
  // Engine outputs
  input wire logic [7:0] periph_rdata,
  input wire logic [10:0] rom_addr,
  input wire logic pix_valid,
  input wire osd_pix_type pix_out
);
  logic hs_ff, vs_ff, lit, sel;
  logic [7:0] sp_ff;
  int line_ff, hcnt_ff;
  assign lit = pix_out.r | pix_out.g | pix_out.b;
  assign sel = periph_addr == START_POS_ADDR;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // Sync edges, line and cycle counts
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hs_ff <= 1'b1;
      vs_ff <= 1'b1;
      line_ff <= 0;
      hcnt_ff <= 0;
    end else begin
      hs_ff <= hsync_n;
      vs_ff <= vsync_n;
      line_ff <= (vsync_n && !vs_ff) ? 0 : line_ff + int'(!hsync_n && hs_ff);
      hcnt_ff <= (hsync_n && !hs_ff) ? 0 : hcnt_ff + 1;
    end
  end
  // Copy of the start register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sp_ff <= 8'h00;
    end else if (periph_wr && sel) begin
      sp_ff <= periph_wdata;
    end
  end
  chk_lit_sets_blank: assert property (pix_valid && lit |-> pix_out.blank)
    else $error("lit dot without blanking");
  chk_stall_holds_pix: assert property (pix_valid && !pix_ready |=> pix_valid && $stable(pix_out))
    else $error("pixel lost under stall");
  chk_unmapped_reads_zero: assert property (!sel |-> periph_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_write_lands: assert property ((periph_wr && sel) ##1 sel |-> periph_rdata == $past(periph_wdata))
    else $error("start register write lost");
  chk_reg_holds: assert property ((!periph_wr && sel) ##1 sel |-> $stable(periph_rdata))
    else $error("start register changed");
  chk_bank_bit: assert property (rom_addr[10] == glyph_rom_bank_select)
    else $error("glyph rom bank bit wrong");
  chk_hstart_gap: assert property ($rose(pix_valid) |-> hcnt_ff >= HBASE_CYC + DOT_CYC * sp_ff[7:4] - 1)
    else $error("pixel before horizontal start");
  chk_vstart_lines: assert property (pix_valid |-> line_ff >= VSTART_BASE_LINES + sp_ff[3:0])
    else $error("pixel before vertical start");
endmodule

bind osd_engine osd_engine_chk osd_engine_chk_inst (
  .clk(clk), .rst(rst), .hsync_n(hsync_n), .vsync_n(vsync_n), .glyph_rom_bank_select(glyph_rom_bank_select),
  .periph_addr(periph_addr), .periph_wr(periph_wr), .periph_wdata(periph_wdata), .pix_ready(pix_ready),
  .periph_rdata(periph_rdata), .rom_addr(rom_addr), .pix_valid(pix_valid), .pix_out(pix_out)
);

// [osd_pix_buf.sv]
`timescale 1ns/1ns
module osd_pix_buf
  import osd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire osd_pix_type in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output osd_pix_type out_data
);
  osd_pix_type mem_ff [2];
  logic wr_ptr_ff;
  logic rd_ptr_ff;
  logic [1:0] cnt_ff;
  logic do_wr;
  logic do_rd;

  assign in_ready = (cnt_ff != 2'h2);
  assign out_valid = (cnt_ff != 2'h0);
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;
  assign out_data = mem_ff[rd_ptr_ff];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_ff[0] <= '0;
      mem_ff[1] <= '0;
    end else if (do_wr) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      cnt_ff <= 2'h0;
    end else begin
      if (do_wr) begin
        wr_ptr_ff <= ~wr_ptr_ff;
      end
      if (do_rd) begin
        rd_ptr_ff <= ~rd_ptr_ff;
      end
      cnt_ff <= cnt_ff + {1'b0, do_wr} - {1'b0, do_rd};
    end
  end
endmodule

// [osd_pkg.sv]
package osd_pkg;
  localparam int CLK_MHZ = 125;
  localparam int DOT_NS = 250;
  localparam int HSTART_BASE_NS = 4250;
  localparam int DOT_CYC = (DOT_NS * CLK_MHZ) / 1000;
  localparam int HBASE_CYC = (HSTART_BASE_NS * CLK_MHZ) / 1000;
  localparam int VSTART_BASE_LINES = 17;
  localparam int CHAR_DOTS = 10;
  localparam int CHAR_LINES = 15;
  localparam int ROW_POSITIONS = 19;
  localparam logic [7:0] START_POS_ADDR = 8'h01;
  localparam logic [7:0] START_POS_RESET = 8'h00;
  localparam logic [3:0] CTRL_STEP = 4'hF;
  localparam int CW_HSIZE_HI = 14;
  localparam int CW_HSIZE_LO = 13;
  localparam int CW_VSIZE_HI = 12;
  localparam int CW_VSIZE_LO = 11;
  localparam int CW_HPOS_HI = 10;
  localparam int CW_HPOS_LO = 7;
  localparam int CW_VPOS_HI = 6;
  localparam int CW_VPOS_LO = 3;
  localparam int PAT_RIM_BIT = 15;
  localparam logic [1:0] TAG_CTRL = 2'h2;
  localparam logic [1:0] TAG_CR = 2'h1;
  localparam logic [1:0] TAG_CHAR = 2'h0;

  typedef struct packed {
    logic [1:0] hsize;
    logic [1:0] vsize;
    logic [3:0] hpos;
    logic [3:0] vpos;
    logic [2:0] color;
  } osd_ctrl_type;

  typedef struct packed {
    logic [1:0] tag;
    logic [6:0] code;
  } osd_item_type;

  typedef struct packed {
    logic r;
    logic g;
    logic b;
    logic blank;
  } osd_pix_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_VWAIT = 3'b001,
    ST_FETCH = 3'b010,
    ST_ROWWAIT = 3'b011,
    ST_HWAIT = 3'b100,
    ST_DRAW = 3'b101,
    ST_LINEEND = 3'b110
  } osd_state_type;

  // Control word fields
  function automatic osd_ctrl_type osd_decode(input logic [15:0] w);
    osd_ctrl_type c;
    c.hsize = w[CW_HSIZE_HI:CW_HSIZE_LO];
    c.vsize = w[CW_VSIZE_HI:CW_VSIZE_LO];
    c.hpos = w[CW_HPOS_HI:CW_HPOS_LO];
    c.vpos = w[CW_VPOS_HI:CW_VPOS_LO];
    c.color = w[2:0];
    return c;
  endfunction
endpackage

// [osd_video_sink.sv]
`timescale 1ns/1ns
module osd_video_sink
  import osd_pkg::*;
(
  // Pixel stream
  input wire logic pix_valid,
  input wire osd_pix_type pix_out,
  output logic pix_ready,
  // Stall control and accepted pixel
  input wire logic stall,
  output logic take,
  output osd_pix_type taken
);
  assign pix_ready = !stall;
  assign take = pix_valid && pix_ready;
  assign taken = pix_out;
endmodule

// [tb_osd_control_data_display_timing.sv]
`timescale 1ns/1ns
module tb_osd_control_data_display_timing;
  import osd_pkg::*;
`define CHECK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; $display("ERROR %0t mismatch", $time); end end
  logic clk, rst, hsync_n, vsync_n, osd_display_on_flag, glyph_rom_bank_select, periph_wr;
  logic pix_valid, pix_ready, stall, stall_en, take, hs_prev;
  logic [7:0] periph_addr, periph_wdata, periph_rdata;
  logic [6:0] vram_idx;
  logic [10:0] rom_addr;
  logic [15:0] rom_data, cw;
  logic [5:0] sel;
  logic [2:0] col_seen;
  osd_item_type vram_item;
  osd_pix_type pix_out, taken;
  int failures, checks_done, seed, hcyc, lit_cnt, first_t;
  int hs_t[2] = '{0, 1};
  int vs_t[2] = '{0, 1};
  int hp_t[2] = '{1, 0};
  int vp_t[2] = '{1, 0};
  int col_t[2] = '{2, 5};
  int sp_t[2] = '{16, 2};
  int len_t[2] = '{1260, 1450};
  osd_engine osd_engine_inst (
    .clk(clk), .rst(rst), .hsync_n(hsync_n), .vsync_n(vsync_n), .osd_display_on_flag(osd_display_on_flag),
    .glyph_rom_bank_select(glyph_rom_bank_select), .periph_addr(periph_addr), .periph_wr(periph_wr),
    .periph_wdata(periph_wdata), .periph_rdata(periph_rdata), .vram_idx(vram_idx), .vram_item(vram_item),
    .rom_addr(rom_addr), .rom_data(rom_data), .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_out(pix_out)
  );
  osd_video_sink osd_video_sink_inst (
    .pix_valid(pix_valid), .pix_out(pix_out), .pix_ready(pix_ready), .stall(stall), .take(take), .taken(taken)
  );
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always_comb begin
    case (vram_idx)
      7'h00: vram_item = {TAG_CTRL, 1'b0, sel};
      7'h01: vram_item = {TAG_CHAR, 7'h05};
      default: vram_item = {TAG_CR, 7'h02};
    endcase
  end
  always_comb begin
    rom_data = 16'h0201;
    if (rom_addr[3:0] == CTRL_STEP) begin
      rom_data = (rom_addr == {glyph_rom_bank_select, sel, CTRL_STEP}) ? cw : 16'h7FFF;
    end
  end
  always @(negedge clk) begin
    stall = stall_en && (($random(seed) & 3) == 0);
  end
  always @(posedge clk) begin
    hcyc = (hsync_n && !hs_prev) ? 0 : hcyc + 1;
    hs_prev = hsync_n;
    if (take) begin
      `CHECK(taken.blank, taken.r | taken.g | taken.b)
      if (taken.r | taken.g | taken.b) begin
        lit_cnt++;
        col_seen = col_seen | {taken.r, taken.g, taken.b};
        if (first_t < 0) first_t = hcyc;
      end
    end
  end
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    periph_addr = a;
    periph_wdata = d;
    periph_wr = 1'b1;
    @(negedge clk);
    periph_wr = 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    periph_addr = a;
    #1;
    `CHECK(periph_rdata, exp)
  endtask
  task automatic frame(input int k);
    int base, top, rows, n, n_lit, first_ln, exp_t, ln;
    rows = 15 * (vs_t[k] + 1);
    base = VSTART_BASE_LINES + (sp_t[k] & 15);
    top = base + vp_t[k] * rows;
    n = 2 * DOT_CYC * (hs_t[k] + 1);
    exp_t = HBASE_CYC + DOT_CYC * (sp_t[k] >> 4) + hp_t[k] * CHAR_DOTS * DOT_CYC * (hs_t[k] + 1);
    n_lit = 0;
    first_ln = 0;
    osd_display_on_flag = 1'b0;
    reg_wr(START_POS_ADDR, 8'(sp_t[k]));
    reg_rd(START_POS_ADDR, 8'(sp_t[k]));
    sel = 6'(5 + 37 * k);
    cw = {1'b0, 2'(hs_t[k]), 2'(vs_t[k]), 4'(hp_t[k]), 4'(vp_t[k]), 3'(col_t[k])};
    glyph_rom_bank_select = k[0];
    stall_en = k[0];
    vsync_n = 1'b0;
    osd_display_on_flag = 1'b1;
    repeat (100) @(negedge clk);
    vsync_n = 1'b1;
    repeat (20) @(negedge clk);
    for (ln = 1; ln <= top + rows + 2; ln++) begin
      hsync_n = 1'b0;
      repeat (8) @(negedge clk);
      hsync_n = 1'b1;
      lit_cnt = 0;
      col_seen = 3'h0;
      first_t = -1;
      repeat ((ln < top) ? 80 : len_t[k]) @(negedge clk);
      if (lit_cnt != 0) begin
        `CHECK(lit_cnt, n)
        `CHECK(col_seen, 3'(col_t[k]))
        if (n_lit == 0) begin
          first_ln = ln;
          if (!stall_en) `CHECK(first_t >= exp_t - 1 && first_t <= exp_t + 4, 1'b1)
        end
        n_lit++;
      end
    end
    `CHECK(n_lit, rows)
    `CHECK(first_ln >= top && first_ln <= top + 1, 1'b1)
  endtask
  task automatic end_of_test;
    if (failures == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    seed = 41;
    {failures, checks_done, hcyc, lit_cnt, first_t} = '0;
    {rst, hsync_n, vsync_n, hs_prev} = 4'hF;
    {osd_display_on_flag, glyph_rom_bank_select, periph_wr, stall, stall_en} = 5'h00;
    {periph_addr, periph_wdata, sel, cw, col_seen} = '0;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    reg_rd(START_POS_ADDR, START_POS_RESET);
    reg_wr(8'h02, 8'hA5);
    reg_rd(8'h02, 8'h00);
    reg_rd(START_POS_ADDR, START_POS_RESET);
    frame(0);
    frame(1);
    stall_en = 1'b0;
    osd_display_on_flag = 1'b0;
    repeat (20) @(negedge clk);
    end_of_test;
  end
  initial begin
    repeat (99000) @(posedge clk);
    failures++;
    end_of_test;
  end
endmodule
